/* File: hdl/mtb_pkg.sv */
// Register map and constants of the microsecond timebase.
package mtb_pkg;
    localparam int          MTB_AW          = 8;
    localparam int          MTB_DW          = 32;
    localparam int          MTB_CW          = 64;
    localparam int          MTB_NALARM      = 4;
    localparam logic [7:0]  MTB_TIME_HI_WR  = 8'h00;
    localparam logic [7:0]  MTB_TIME_LO_WR  = 8'h04;
    localparam logic [7:0]  MTB_TIME_HI_RD  = 8'h08;
    localparam logic [7:0]  MTB_TIME_LO_RD  = 8'h0c;
    localparam logic [7:0]  MTB_ALARM_BASE  = 8'h10;
    localparam logic [7:0]  MTB_ARMED       = 8'h20;
    localparam logic [7:0]  MTB_RAW_HI      = 8'h24;
    localparam logic [7:0]  MTB_RAW_LO      = 8'h28;
    localparam logic [7:0]  MTB_INT_RAW     = 8'h34;
    localparam logic [7:0]  MTB_INT_EN      = 8'h38;
    localparam logic [63:0] MTB_COUNT_RST   = 64'h0;
    localparam logic [31:0] MTB_WORD_RST    = 32'h0;
    localparam logic [3:0]  MTB_BITS_RST    = 4'h0;
endpackage

/* File: hdl/mtb_timebase.sv */
// Microsecond timebase: 64-bit counter, latched and raw reads, four alarms.
`timescale 1ns/1ps
module mtb_timebase (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst,
    input  wire logic                       i_ce,
    input  wire logic                       i_us_tick,
    input  wire logic [mtb_pkg::MTB_AW-1:0] i_addr,
    input  wire logic [mtb_pkg::MTB_DW-1:0] i_wdata,
    input  wire logic                       i_wr,
    input  wire logic                       i_rd,
    output logic      [mtb_pkg::MTB_DW-1:0] o_rdata,
    output logic      [3:0]                 o_irq
);
    import mtb_pkg::*;

    // ========================================
    // Tick synchroniser
    logic        tick_s1_reg;
    logic        tick_s2_reg;
    logic        tick_s3_reg;
    logic        tick_lvl_reg;
    logic        tick_rise;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tick_s1_reg  <= 1'b0;
            tick_s2_reg  <= 1'b0;
            tick_s3_reg  <= 1'b0;
            tick_lvl_reg <= 1'b0;
        end else if (i_ce) begin
            tick_s1_reg <= i_us_tick;
            tick_s2_reg <= tick_s1_reg;
            tick_s3_reg <= tick_s2_reg;
            if (tick_s2_reg == tick_s3_reg) begin
                tick_lvl_reg <= tick_s3_reg;
            end
        end
    end

    // A tick counts once, when the filtered level goes high.
    assign tick_rise = tick_s2_reg & tick_s3_reg & ~tick_lvl_reg;

    // ========================================
    // Bus decode
    logic        wr_hi;
    logic        wr_lo;
    logic        rd_lo;
    logic        rd_hi;
    logic        wr_armed;
    logic        wr_intr;
    logic        wr_inte;
    logic [3:0]  wr_alarm;

    assign wr_hi    = i_ce & i_wr & (i_addr == MTB_TIME_HI_WR);
    assign wr_lo    = i_ce & i_wr & (i_addr == MTB_TIME_LO_WR);
    assign rd_lo    = i_ce & i_rd & (i_addr == MTB_TIME_LO_RD);
    assign rd_hi    = i_ce & i_rd & (i_addr == MTB_TIME_HI_RD);
    assign wr_armed = i_ce & i_wr & (i_addr == MTB_ARMED);
    assign wr_intr  = i_ce & i_wr & (i_addr == MTB_INT_RAW);
    assign wr_inte  = i_ce & i_wr & (i_addr == MTB_INT_EN);

    // ========================================
    // Counter
    logic [63:0] count_reg;
    logic [31:0] lo_pend_reg;
    logic [31:0] hi_latch_reg;
    logic        latched_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            count_reg <= MTB_COUNT_RST;
        end else if (wr_hi) begin
            count_reg <= {i_wdata, lo_pend_reg};
        end else if (i_ce && tick_rise) begin
            count_reg <= count_reg + 64'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            lo_pend_reg <= MTB_WORD_RST;
        end else if (wr_lo) begin
            lo_pend_reg <= i_wdata;
        end
    end

    // Reading the low half freezes the high half until it is read.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            hi_latch_reg <= MTB_WORD_RST;
            latched_reg  <= 1'b0;
        end else if (rd_lo) begin
            hi_latch_reg <= count_reg[63:32];
            latched_reg  <= 1'b1;
        end else if (rd_hi) begin
            latched_reg <= 1'b0;
        end
    end

    // ========================================
    // Alarms
    logic [31:0] target_reg [MTB_NALARM];
    logic [3:0]  armed_reg;
    logic [3:0]  intr_reg;
    logic [3:0]  inte_reg;
    logic [3:0]  fire;

    genvar g;
    generate
        for (g = 0; g < MTB_NALARM; g++) begin : g_alarm
            assign wr_alarm[g] = i_ce & i_wr & (i_addr == MTB_ALARM_BASE + 8'(4 * g));
            // A software disarm in the same cycle suppresses the match.
            assign fire[g]     = i_ce & armed_reg[g] & ~(wr_armed & i_wdata[g])
                                 & (target_reg[g] == count_reg[31:0]);

            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    target_reg[g] <= MTB_WORD_RST;
                end else if (wr_alarm[g]) begin
                    target_reg[g] <= i_wdata;
                end
            end

            // A new target write wins over a disarm in the same cycle.
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    armed_reg[g] <= 1'b0;
                end else if (wr_alarm[g]) begin
                    armed_reg[g] <= 1'b1;
                end else if (fire[g] || (wr_armed && i_wdata[g])) begin
                    armed_reg[g] <= 1'b0;
                end
            end

            // A fire in the clearing cycle keeps the bit set.
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    intr_reg[g] <= 1'b0;
                end else if (fire[g]) begin
                    intr_reg[g] <= 1'b1;
                end else if (wr_intr && i_wdata[g]) begin
                    intr_reg[g] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            inte_reg <= MTB_BITS_RST;
        end else if (wr_inte) begin
            inte_reg <= i_wdata[3:0];
        end
    end

    assign o_irq = intr_reg & inte_reg;

    // ========================================
    // Read data
    logic [31:0] rdata_next;

    always_comb begin
        rdata_next = MTB_WORD_RST;
        unique case (i_addr)
            MTB_TIME_HI_RD: rdata_next = latched_reg ? hi_latch_reg : count_reg[63:32];
            MTB_TIME_LO_RD: rdata_next = count_reg[31:0];
            MTB_ALARM_BASE: rdata_next = target_reg[0];
            MTB_ALARM_BASE + 8'h04: rdata_next = target_reg[1];
            MTB_ALARM_BASE + 8'h08: rdata_next = target_reg[2];
            MTB_ALARM_BASE + 8'h0c: rdata_next = target_reg[3];
            MTB_ARMED: rdata_next = {28'h0, armed_reg};
            MTB_RAW_HI: rdata_next = count_reg[63:32];
            MTB_RAW_LO: rdata_next = count_reg[31:0];
            MTB_INT_RAW: rdata_next = {28'h0, intr_reg};
            MTB_INT_EN: rdata_next = {28'h0, inte_reg};
            default: rdata_next = MTB_WORD_RST;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= MTB_WORD_RST;
        end else if (i_ce) begin
            o_rdata <= i_rd ? rdata_next : MTB_WORD_RST;
        end
    end

    // ========================================
    // Assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_inc;
        i_ce && tick_rise && !wr_hi |=> count_reg == $past(count_reg) + 64'h1;
    endproperty
    a_inc: assert property (p_inc) else $error("count did not step by one");

    property p_hold;
        !(i_ce && tick_rise) && !wr_hi |=> $stable(count_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved without tick");

    property p_latch;
        latched_reg && rd_hi |=> o_rdata == $past(hi_latch_reg) && !latched_reg;
    endproperty
    a_latch: assert property (p_latch) else $error("high half not frozen");

    property p_raw;
        i_ce && i_rd && i_addr == MTB_RAW_LO |=> o_rdata == $past(count_reg[31:0]) && $stable(latched_reg);
    endproperty
    a_raw: assert property (p_raw) else $error("raw read wrong");

    property p_arm;
        wr_alarm[0] |=> armed_reg[0] && target_reg[0] == $past(i_wdata);
    endproperty
    a_arm: assert property (p_arm) else $error("alarm not armed");

    property p_disarm;
        fire[1] && !wr_alarm[1] |=> !armed_reg[1] && intr_reg[1];
    endproperty
    a_disarm: assert property (p_disarm) else $error("fired alarm still armed");

    property p_intr;
        intr_reg[2] && !(wr_intr && i_wdata[2]) |=> intr_reg[2];
    endproperty
    a_intr: assert property (p_intr) else $error("raw interrupt lost");

    property p_lowhold;
        wr_lo && !tick_rise |=> $stable(count_reg) && lo_pend_reg == $past(i_wdata);
    endproperty
    a_lowhold: assert property (p_lowhold) else $error("low write leaked to count");

    property p_disarm_sw;
        wr_armed && i_wdata[1] && !wr_alarm[1] |=> !armed_reg[1] ##1 (!intr_reg[1] || $past(intr_reg[1], 2));
    endproperty
    a_disarm_sw: assert property (p_disarm_sw) else $error("software disarm failed");

    property p_irq;
        fire[0] && inte_reg[0] && !wr_inte |=> o_irq[0];
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_freeze;
        rd_lo |=> latched_reg && hi_latch_reg == $past(count_reg[63:32]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("high half not captured");

    property p_frozen;
        latched_reg && !rd_lo |=> $stable(hi_latch_reg);
    endproperty
    a_frozen: assert property (p_frozen) else $error("captured high half moved");

    property p_raw_hi;
        i_ce && i_rd && i_addr == MTB_RAW_HI |=> o_rdata == $past(count_reg[63:32]) && $stable(latched_reg);
    endproperty
    a_raw_hi: assert property (p_raw_hi) else $error("raw high read wrong");

    property p_load;
        wr_hi |=> count_reg == {$past(i_wdata), $past(lo_pend_reg)};
    endproperty
    a_load: assert property (p_load) else $error("high write did not load the count");

    property p_clr;
        intr_reg[0] && wr_intr && i_wdata[0] && !fire[0] |=> !intr_reg[0];
    endproperty
    a_clr: assert property (p_clr) else $error("raw interrupt not cleared");

    property p_inte;
        wr_inte |=> inte_reg == $past(i_wdata[3:0]);
    endproperty
    a_inte: assert property (p_inte) else $error("enable bits not stored");

    property p_ce;
        !i_ce |=> $stable(count_reg) && $stable(armed_reg) && $stable(intr_reg) && $stable(inte_reg);
    endproperty
    a_ce: assert property (p_ce) else $error("state moved while disabled");

    property p_reset;
        disable iff (1'b0) i_rst |=> count_reg == MTB_COUNT_RST && armed_reg == MTB_BITS_RST
            && intr_reg == MTB_BITS_RST && inte_reg == MTB_BITS_RST;
    endproperty
    a_reset: assert property (p_reset) else $error("reset left state set");

    property p_tick_once;
        i_ce && tick_rise |=> !tick_rise;
    endproperty
    a_tick_once: assert property (p_tick_once) else $error("tick counted twice");
endmodule

/* File: tb/mtb_timebase_test.sv */
// Self-checking testbench of the microsecond timebase.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module mtb_timebase_test;
    import mtb_pkg::*;
    logic              i_clk_sys = 1'b0;
    logic              i_rst     = 1'b1;
    logic              i_ce      = 1'b1;
    logic              i_us_tick = 1'b0;
    logic [MTB_AW-1:0] i_addr    = 8'h00;
    logic [MTB_DW-1:0] i_wdata   = 32'h0;
    logic              i_wr      = 1'b0;
    logic              i_rd      = 1'b0;
    logic [MTB_DW-1:0] o_rdata;
    logic [3:0]        o_irq;
    int                num_errors  = 0;
    int                checks_done = 0;
    int                cycles      = 0;
    logic [31:0]       d;
    logic [7:0]        zero_addr [10] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h34, 8'h38, 8'h24, 8'h28, 8'h3c};

    mtb_timebase dut_u (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_us_tick (i_us_tick),
        .i_addr    (i_addr),
        .i_wdata   (i_wdata),
        .i_wr      (i_wr),
        .i_rd      (i_rd),
        .o_rdata   (o_rdata),
        .o_irq     (o_irq)
    );

    initial begin
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    // ==========================================================================
    // Bus, tick and closing tasks
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the expected run length.
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_clk_sys);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd   <= 1'b0;
        #1 v = o_rdata;
    endtask

    // Each level is held long enough for the synchroniser and its filter.
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_clk_sys);
            i_us_tick <= 1'b1;
            repeat (4) @(posedge i_clk_sys);
            i_us_tick <= 1'b0;
            repeat (4) @(posedge i_clk_sys);
        end
    endtask

    // ==========================================================================
    // Scenarios
    task automatic t_reset();
        foreach (zero_addr[i]) begin
            rd(zero_addr[i], d);
            `CHK(d, 32'h0)
        end
        `CHK(o_irq, 4'h0)
    endtask

    task automatic t_count();
        tick(5);
        rd(MTB_RAW_LO, d);
        `CHK(d, 32'h5)
        repeat (20) @(posedge i_clk_sys);
        rd(MTB_RAW_LO, d);
        `CHK(d, 32'h5)
    endtask

    task automatic t_pair();
        wr(MTB_TIME_LO_WR, 32'hffff_fffe);
        rd(MTB_RAW_LO, d);
        `CHK(d, 32'h5)
        wr(MTB_TIME_HI_WR, 32'h1);
        rd(MTB_RAW_LO, d);
        `CHK(d, 32'hffff_fffe)
        rd(MTB_RAW_HI, d);
        `CHK(d, 32'h1)
        rd(MTB_TIME_LO_RD, d);
        `CHK(d, 32'hffff_fffe)
        tick(2);
        rd(MTB_RAW_HI, d);
        `CHK(d, 32'h2)
        rd(MTB_TIME_HI_RD, d);
        `CHK(d, 32'h1)
        rd(MTB_TIME_HI_RD, d);
        `CHK(d, 32'h2)
    endtask

    // The upper half is 2 here, so a match on the low half alone is shown.
    task automatic t_alarms();
        wr(MTB_INT_EN, 32'hf);
        for (int n = 0; n < 4; n++) begin
            wr(MTB_ALARM_BASE + 8'(4 * n), 32'(n + 1));
            rd(MTB_ARMED, d);
            `CHK(d, 32'(1 << n))
            tick(1);
            rd(MTB_ARMED, d);
            `CHK(d, 32'h0)
            rd(MTB_INT_RAW, d);
            `CHK(d, 32'(1 << n))
            `CHK(o_irq, 4'(1 << n))
            wr(MTB_INT_RAW, 32'(1 << n));
            rd(MTB_INT_RAW, d);
            `CHK(d, 32'h0)
            `CHK(o_irq, 4'h0)
        end
    endtask

    task automatic t_mask_disarm();
        wr(MTB_INT_EN, 32'he);
        wr(MTB_ALARM_BASE, 32'h5);
        tick(1);
        rd(MTB_INT_RAW, d);
        `CHK(d, 32'h1)
        `CHK(o_irq, 4'h0)
        wr(MTB_INT_EN, 32'h1);
        #1;
        `CHK(o_irq, 4'h1)
        wr(MTB_INT_RAW, 32'h1);
        wr(MTB_ALARM_BASE + 8'h04, 32'h6);
        wr(MTB_ARMED, 32'h2);
        rd(MTB_ARMED, d);
        `CHK(d, 32'h0)
        tick(1);
        rd(MTB_INT_RAW, d);
        `CHK(d, 32'h0)
        rd(MTB_ALARM_BASE + 8'h04, d);
        `CHK(d, 32'h6)
    endtask

    // Clock enable low freezes the count, the synchroniser and the bus.
    task automatic t_freeze();
        @(posedge i_clk_sys);
        i_ce <= 1'b0;
        tick(1);
        wr(MTB_INT_EN, 32'hf);
        i_ce <= 1'b1;
        rd(MTB_RAW_LO, d);
        `CHK(d, 32'h6)
        rd(MTB_INT_EN, d);
        `CHK(d, 32'h1)
    endtask

    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_reset();
        t_count();
        t_pair();
        t_alarms();
        t_mask_disarm();
        t_freeze();
        tally_and_finish();
    end
endmodule
